// ---- rtl/dcf_fifo_port.sv ----
/*
 * Dual-clock buffer port: 18-bit words written on the write clock, read on the read clock,
 * with programmable almost flags, half-full or write-cascade pin, read cascade and retransmit.
 * Assumes rst is applied after power-up before any access, and that the cascade inputs and
 * the first-load strap are tied as the system configuration requires.
 */
// Behaviour
// RULE1: Separate 18-bit input and output buses.
// RULE2: Write stores word when enabled, not full.
// RULE3: Read advances when enabled and not empty.
// RULE4: Offset-load write goes to offset register.
// RULE5: Offset-load read outputs offset register.
// RULE6: Empty flag low when empty, read clock.
// RULE7: Full flag low when full, write clock.
// RULE8: Almost-empty low within empty offset.
// RULE9: Almost-full low within full offset.
// RULE10: Sync select picks registered or asynchronous flags.
// RULE11: Output enable low drives output bus.
// RULE12: Reset empties buffer, clears both pointers.
// RULE13: System resets device after power-up.
// RULE14: Dual pin: half-full or write cascade out.
// RULE15: First-load strap low on first device.
// RULE16: Standalone retransmit strobed on shared input.
// RULE17: Unused cascade inputs tied low.
// RULE18: Read cascade out hands reading onward.
// RULE19: Two 16-bit offset registers.
// RULE20: Offset accesses alternate empty then full.
// RULE21: Retransmit rewinds read pointer to start.
// RULE22: Half-full when count exceeds half depth.
`timescale 1ns/1ns
module dcf_fifo_port #(
    parameter int DEPTH = dcf_pkg::DEPTH,
    parameter int AW = dcf_pkg::ADDR_W
) (
    input wire logic wrClk,
    input wire logic rdClk,
    input wire logic rst,
    input wire logic [dcf_pkg::WORD_W-1:0] dataIn,
    output logic [dcf_pkg::WORD_W-1:0] dataOut,
    output logic dataOutEn,
    input wire logic writeEnN,
    input wire logic readEnN,
    input wire logic outputEnN,
    input wire logic offsetAccessSelectN,
    input wire logic firstLoadStrapN,
    input wire logic cascadeMode,
    input wire logic retransmitStrobe,
    input wire logic writeCascadeIn,
    input wire logic readCascadeIn,
    input wire logic almostFlagSyncSelect,
    output logic writeCascadeOut,
    output logic readCascadeOut,
    output dcf_pkg::dcf_flags_t flags
);
    localparam int PW = AW + 1;

    // ----------------------------------------------------------------
    // Pointers and crossings
    // ----------------------------------------------------------------
    logic [PW-1:0] wrPtr_ff, rdPtr_ff, nxt_wrPtr, nxt_rdPtr;
    logic [PW-1:0] wrGray_ff, rdGray_ff, wrGraySync, rdGraySync;
    logic [PW-1:0] wrPtrInRd, rdPtrInWr;
    logic [PW-1:0] startPtr_ff;
    logic [dcf_pkg::OFFSET_W-1:0] emptyOffset_ff, fullOffset_ff;
    logic wrOffsetSel_ff, rdOffsetSel_ff;
    logic emptyN_ff, fullN_ff, almostEmptyN_ff, almostFullN_ff;
    logic [dcf_pkg::WORD_W-1:0] ramData, offsetRead_ff;
    logic outFromOffset_ff;
    logic ramValid_ff;
    logic wrActive_ff, rdActive_ff;
    logic wrFire, rdFire, offWr, offRd, rtFire;
    logic [PW-1:0] wrCount, rdCount, asyncCount;

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        for (int i = PW - 1; i >= 0; i--) begin
            b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction

    // The far pointer arrives two or three clocks late, which makes the flags pessimistic except write-side ones after a retransmit rewind.
    dcf_sync2 #(.W(PW)) u_wr2rd (.clk(rdClk), .rst(rst), .din(wrGray_ff), .dout(wrGraySync));
    dcf_sync2 #(.W(PW)) u_rd2wr (.clk(wrClk), .rst(rst), .din(rdGray_ff), .dout(rdGraySync));

    assign wrPtrInRd = gray2bin(wrGraySync);
    assign rdPtrInWr = gray2bin(rdGraySync);
    assign wrCount = wrPtr_ff - rdPtrInWr;
    assign rdCount = wrPtrInRd - rdPtr_ff;
    // Asynchronous mode compares the raw pointers; glitches are the user's trade for zero latency.
    assign asyncCount = wrPtr_ff - rdPtr_ff;

    // ----------------------------------------------------------------
    // Cascade token
    // ----------------------------------------------------------------
    // In a chain only the token holder writes or reads; the first device starts with both tokens.
    // Handing the token on at the last location lets the next device take the very next word.
    always_ff @(posedge wrClk or posedge rst) begin
        if (rst) begin
            wrActive_ff <= 1'b0;
        end else if (!cascadeMode) begin
            wrActive_ff <= 1'b1;
        end else if (writeCascadeIn) begin
            wrActive_ff <= 1'b1;
        end else if (wrFire && (nxt_wrPtr[AW-1:0] == '0)) begin
            wrActive_ff <= 1'b0;
        end else if (wrPtr_ff == '0 && !firstLoadStrapN && !writeCascadeOut && wrCount == '0) begin
            // RULE15 first device start
            wrActive_ff <= 1'b1;
        end
    end

    always_ff @(posedge rdClk or posedge rst) begin
        if (rst) begin
            rdActive_ff <= 1'b0;
        end else if (!cascadeMode) begin
            rdActive_ff <= 1'b1;
        end else if (readCascadeIn) begin
            rdActive_ff <= 1'b1;
        end else if (rdFire && (nxt_rdPtr[AW-1:0] == '0)) begin
            rdActive_ff <= 1'b0;
        end else if (rdPtr_ff == '0 && !firstLoadStrapN && !readCascadeOut && rdCount == '0) begin
            rdActive_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Write side
    // ----------------------------------------------------------------
    // RULE2 gated store
    assign wrFire = !writeEnN && offsetAccessSelectN && fullN_ff && wrActive_ff;
    // RULE4 offset load
    assign offWr = !writeEnN && !offsetAccessSelectN;
    assign nxt_wrPtr = wrPtr_ff + PW'(1);

    // RULE1 word store
    dcf_ram #(.WIDTH(dcf_pkg::WORD_W), .AW(AW)) u_ram (
        .wrClk(wrClk), .wrEn(wrFire), .wrAddr(wrPtr_ff[AW-1:0]), .wrData(dataIn),
        .rdClk(rdClk), .rdEn(rdFire), .rdAddr(rdPtr_ff[AW-1:0]), .rdData(ramData)
    );

    // RULE12 pointer clear
    always_ff @(posedge wrClk or posedge rst) begin
        if (rst) begin
            wrPtr_ff <= '0;
            wrGray_ff <= '0;
        end else if (wrFire) begin
            wrPtr_ff <= nxt_wrPtr;
            wrGray_ff <= bin2gray(nxt_wrPtr);
        end
    end

    // RULE19 offset registers
    always_ff @(posedge wrClk or posedge rst) begin
        if (rst) begin
            emptyOffset_ff <= dcf_pkg::EMPTY_OFFSET_RST;
            fullOffset_ff <= dcf_pkg::FULL_OFFSET_RST;
            wrOffsetSel_ff <= 1'b0;
        end else if (offWr) begin
            // RULE20 alternate target
            if (!wrOffsetSel_ff) begin
                emptyOffset_ff <= dataIn[dcf_pkg::OFFSET_W-1:0];
            end else begin
                fullOffset_ff <= dataIn[dcf_pkg::OFFSET_W-1:0];
            end
            wrOffsetSel_ff <= !wrOffsetSel_ff;
        end
    end

    // The flag looks one write ahead, so the word that fills the store lowers it at the same edge.
    // RULE7 full flag
    always_ff @(posedge wrClk or posedge rst) begin
        if (rst) begin
            fullN_ff <= 1'b1;
        end else begin
            fullN_ff <= !(((wrCount + (wrFire ? PW'(1) : PW'(0))) >= PW'(DEPTH)));
        end
    end

    // RULE9 almost full, write clock
    always_ff @(posedge wrClk or posedge rst) begin
        if (rst) begin
            almostFullN_ff <= 1'b1;
        end else begin
            almostFullN_ff <= !(((wrCount + (wrFire ? PW'(1) : PW'(0)))
                                >= PW'(DEPTH) - PW'(fullOffset_ff)));
        end
    end

    // ----------------------------------------------------------------
    // Read side
    // ----------------------------------------------------------------
    // RULE3 gated advance
    assign rdFire = !readEnN && offsetAccessSelectN && emptyN_ff && rdActive_ff;
    // RULE5 offset read
    assign offRd = !readEnN && !offsetAccessSelectN;
    // RULE16 standalone only
    assign rtFire = retransmitStrobe && !cascadeMode;
    assign nxt_rdPtr = rdPtr_ff + PW'(1);

    // Start of the replay region: location zero, held from reset, where the first word written after reset is stored.
    always_ff @(posedge rdClk or posedge rst) begin
        if (rst) begin
            startPtr_ff <= '0;
        end else begin
            startPtr_ff <= startPtr_ff;
        end
    end

    always_ff @(posedge rdClk or posedge rst) begin
        if (rst) begin
            rdPtr_ff <= '0;
            rdGray_ff <= '0;
        end else if (rtFire) begin
            // RULE21 rewind read
            rdPtr_ff <= startPtr_ff;
            rdGray_ff <= bin2gray(startPtr_ff);
        end else if (rdFire) begin
            rdPtr_ff <= nxt_rdPtr;
            rdGray_ff <= bin2gray(nxt_rdPtr);
        end
    end

    // Readback keeps its own alternation, so reading the offsets never disturbs the write sequence.
    always_ff @(posedge rdClk or posedge rst) begin
        if (rst) begin
            rdOffsetSel_ff <= 1'b0;
            offsetRead_ff <= dcf_pkg::WORD_RST;
            outFromOffset_ff <= 1'b0;
        end else if (offRd) begin
            offsetRead_ff <= {2'b00, rdOffsetSel_ff ? fullOffset_ff : emptyOffset_ff};
            rdOffsetSel_ff <= !rdOffsetSel_ff;
            outFromOffset_ff <= 1'b1;
        end else if (rdFire) begin
            outFromOffset_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Output word qualifier
    // ----------------------------------------------------------------
    // The store has no reset, so until the first read after reset the output shows zeros.
    // This also keeps stale words of an earlier run off the bus once the buffer is emptied by reset.
    always_ff @(posedge rdClk or posedge rst) begin
        if (rst) begin
            ramValid_ff <= 1'b0;
        end else if (rdFire) begin
            ramValid_ff <= 1'b1;
        end
    end

    // A retransmit drops the flag for one read clock while the rewound count settles.
    // RULE6 empty flag
    always_ff @(posedge rdClk or posedge rst) begin
        if (rst) begin
            emptyN_ff <= 1'b0;
        end else begin
            emptyN_ff <= !((rdCount - (rdFire ? PW'(1) : PW'(0))) == '0) && !rtFire;
        end
    end

    // RULE8 almost empty, read clock
    always_ff @(posedge rdClk or posedge rst) begin
        if (rst) begin
            almostEmptyN_ff <= 1'b0;
        end else begin
            almostEmptyN_ff <= ((rdCount - (rdFire ? PW'(1) : PW'(0))) > PW'(emptyOffset_ff));
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Data holds the last read word; an empty buffer keeps it through refused reads.
    assign dataOut = outFromOffset_ff ? offsetRead_ff : (ramValid_ff ? ramData : dcf_pkg::WORD_RST);
    // RULE11 output drive
    assign dataOutEn = !outputEnN && (!cascadeMode || rdActive_ff);

    // RULE18 read token out
    assign readCascadeOut = cascadeMode && rdActive_ff && rdFire && (nxt_rdPtr[AW-1:0] == '0);
    // RULE14 dual pin
    assign writeCascadeOut = cascadeMode && wrActive_ff && wrFire && (nxt_wrPtr[AW-1:0] == '0);

    always_comb begin
        flags.emptyFlagN = emptyN_ff;
        flags.fullFlagN = fullN_ff;
        // RULE10 flag timing select
        if (almostFlagSyncSelect) begin
            flags.almostEmptyFlagN = asyncCount > PW'(emptyOffset_ff);
            flags.almostFullFlagN = asyncCount < PW'(DEPTH) - PW'(fullOffset_ff);
        end else begin
            flags.almostEmptyFlagN = almostEmptyN_ff;
            flags.almostFullFlagN = almostFullN_ff;
        end
        // Half-full follows the write side count; a reader sees it late by the synchroniser delay.
        // RULE22 half full
        flags.halfFullFlagN = cascadeMode ? !writeCascadeOut : !(wrCount > PW'(DEPTH / 2));
    end
endmodule // dcf_fifo_port

// ---- rtl/dcf_pkg.sv ----
/*
 * Package for the dual-clock cascadable buffer port: widths, depth, reset values and grouped status type.
 * Assumes nothing of its surroundings; every design file names its items with the package scope.
 */
package dcf_pkg;
    // ----------------------------------------------------------------
    // Widths and depth
    // ----------------------------------------------------------------
    localparam int WORD_W = 18;
    localparam int OFFSET_W = 16;
    localparam int ADDR_W = 13;
    localparam int DEPTH = 8192;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] EMPTY_OFFSET_RST = 16'h007F;
    localparam logic [15:0] FULL_OFFSET_RST = 16'h007F;
    localparam logic [17:0] WORD_RST = 18'h00000;

    // ----------------------------------------------------------------
    // Status flags, all active low
    // ----------------------------------------------------------------
    typedef struct packed {
        logic emptyFlagN;
        logic almostEmptyFlagN;
        logic halfFullFlagN;
        logic almostFullFlagN;
        logic fullFlagN;
    } dcf_flags_t;
endpackage

// ---- rtl/dcf_ram.sv ----
/*
 * Simple dual-port word store: one write port on the write clock, registered read on the read clock.
 * Assumes the caller never writes a full store and reads only locations that hold data.
 */
`timescale 1ns/1ns
module dcf_ram #(
    parameter int WIDTH = 18,
    parameter int AW = 13
) (
    input wire logic wrClk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic rdClk,
    input wire logic rdEn,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge wrClk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge rdClk) begin
        if (rdEn) begin
            rdData <= mem[rdAddr];
        end
    end
endmodule // dcf_ram

// ---- rtl/dcf_sync2.sv ----
/*
 * Two-flop synchroniser for a gray-coded pointer bus.
 * Assumes the input changes by at most one bit per source clock.
 */
`timescale 1ns/1ns
module dcf_sync2 #(
    parameter int W = 14
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1_ff;

    // The first stage is read only by the second.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= '0;
            dout <= '0;
        end else begin
            stage1_ff <= din;
            dout <= stage1_ff;
        end
    end
endmodule // dcf_sync2

// ---- sim/dcf_fifo_port_checker.sv ----
/*
 * Checker for the buffer port flags, refused reads and output drive.
 * Assumes standalone use; bound to every instance of the port.
 */
`timescale 1ns/1ns
module dcf_fifo_port_checker (
    input wire logic wrClk,
    input wire logic rdClk,
    input wire logic rst,
    input wire logic [dcf_pkg::WORD_W-1:0] dataOut,
    input wire logic dataOutEn,
    input wire logic writeEnN,
    input wire logic readEnN,
    input wire logic outputEnN,
    input wire logic offsetAccessSelectN,
    input wire logic cascadeMode,
    input wire logic retransmitStrobe,
    input wire logic almostFlagSyncSelect,
    input wire dcf_pkg::dcf_flags_t flags
);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    rst_rd_a: assert property (@(posedge rdClk) disable iff (rst) $fell(rst) |-> !flags.emptyFlagN)
        else $error("empty flag high after reset");
    rst_wr_a: assert property (@(posedge wrClk) disable iff (rst)
        $fell(rst) |-> flags.fullFlagN && flags.halfFullFlagN)
        else $error("full or half flag low after reset");
    oe_off_a: assert property (@(posedge rdClk) disable iff (rst) outputEnN |-> !dataOutEn)
        else $error("bus driven while output enable high");
    oe_on_a: assert property (@(posedge rdClk) disable iff (rst) !outputEnN && !cascadeMode |-> dataOutEn)
        else $error("bus not driven while output enable low");
    empty_enter_a: assert property (@(posedge rdClk) disable iff (rst)
        $fell(flags.emptyFlagN) |-> !$past(readEnN) || $past(retransmitStrobe))
        else $error("empty flag fell without a read");
    empty_hold_a: assert property (@(posedge rdClk) disable iff (rst)
        !flags.emptyFlagN && offsetAccessSelectN && !retransmitStrobe |=> $stable(dataOut))
        else $error("output word changed while empty");
    full_enter_a: assert property (@(posedge wrClk) disable iff (rst) $fell(flags.fullFlagN) |-> !$past(writeEnN))
        else $error("full flag fell without a write");
    half_enter_a: assert property (@(posedge wrClk) disable iff (rst)
        !cascadeMode && $fell(flags.halfFullFlagN) |-> !$past(writeEnN))
        else $error("half flag fell without a write");
    afull_sync_a: assert property (@(posedge wrClk) disable iff (rst)
        !almostFlagSyncSelect && $fell(flags.almostFullFlagN) |-> !$past(writeEnN))
        else $error("registered almost full fell without a write");
endmodule // dcf_fifo_port_checker

bind dcf_fifo_port dcf_fifo_port_checker u_dcf_fifo_port_checker (.wrClk, .rdClk, .rst, .dataOut, .dataOutEn,
    .writeEnN, .readEnN, .outputEnN, .offsetAccessSelectN, .cascadeMode, .retransmitStrobe,
    .almostFlagSyncSelect, .flags);

// ---- sim/dcf_fifo_port_tb_top.sv ----
/*
 * Bench for the buffer port: offsets, fill, drain, drive, reset, replay.
 * Assumes a standalone device of depth 16 with cascade inputs tied low.
 */
`timescale 1ns/1ns
module dcf_fifo_port_tb_top;
    logic wrClk, rdClk, rst, go, readEnN, outputEnN, offsetAccessSelectN, rtx, syncSel, writeEnN, dataOutEn, busy;
    logic cascade, writeCascadeOut, readCascadeOut;
    logic [7:0] n;
    logic [17:0] base, dataIn, dataOut, busLevel;
    dcf_pkg::dcf_flags_t flags;
    int failures = 0;
    int checked = 0;
    assign busLevel = dataOutEn ? dataOut : 'z;
    dcf_fifo_port #(.DEPTH(16), .AW(4)) u_dcf_fifo_port (.wrClk, .rdClk, .rst, .dataIn, .dataOut, .dataOutEn,
        .writeEnN, .readEnN, .outputEnN, .offsetAccessSelectN, .firstLoadStrapN(1'h0), .cascadeMode(cascade),
        .retransmitStrobe(rtx), .writeCascadeIn(1'h0), .readCascadeIn(1'h0), .almostFlagSyncSelect(syncSel),
        .writeCascadeOut, .readCascadeOut, .flags);
    dcf_producer_model u_dcf_producer_model (.clk(wrClk), .rst, .go, .n, .base, .writeEnN, .dataIn, .busy);
    initial begin
        wrClk = 1'h0;
        forever #50 wrClk = ~wrClk;
    end
    initial begin
        rdClk = 1'h0;
        forever #35 rdClk = ~rdClk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic write(input logic [7:0] cnt, input logic [17:0] b);
        @(posedge wrClk);
        n <= cnt;
        base <= b;
        go <= 1'h1;
        @(posedge wrClk);
        go <= 1'h0;
        @(negedge wrClk);
        for (int i = 0; i < 60 && busy !== 1'h0; i++) @(negedge wrClk);
        check("producer idle", busy, 18'h0);
    endtask
    task automatic rd(input logic [17:0] exp);
        for (int i = 0; i < 20 && offsetAccessSelectN && flags.emptyFlagN !== 1'h1; i++) @(negedge rdClk);
        @(posedge rdClk);
        readEnN <= 1'h0;
        @(posedge rdClk);
        readEnN <= 1'h1;
        #1 check("read word", offsetAccessSelectN ? dataOut : {2'h0, dataOut[15:0]}, exp);
    endtask
    task automatic t_offsets();
        @(posedge wrClk);
        offsetAccessSelectN <= 1'h0;
        write(8'h02, 18'h00002);
        rd(18'h00002);
        rd(18'h00003);
        @(posedge wrClk);
        offsetAccessSelectN <= 1'h1;
        check("empty", flags.emptyFlagN, 18'h0);
        $display("offsets done");
    endtask
    task automatic t_fill();
        write(8'h0C, 18'h10000);
        repeat (6) @(negedge wrClk);
        check("almost full", flags.almostFullFlagN, 18'h1);
        check("half full", flags.halfFullFlagN, 18'h0);
        check("almost empty", flags.almostEmptyFlagN, 18'h1);
        write(8'h06, 18'h1000C);
        repeat (6) @(negedge wrClk);
        check("full", flags.fullFlagN, 18'h0);
        check("almost full", flags.almostFullFlagN, 18'h0);
        check("write cascade out", writeCascadeOut, 18'h0);
        check("read cascade out", readCascadeOut, 18'h0);
        $display("fill done");
    endtask
    task automatic t_drain();
        for (int i = 0; i < 16; i++) begin
            rd(18'(18'h10000 + i));
            if (i == 12 || i == 13) begin
                repeat (4) @(negedge rdClk);
                check("almost empty", flags.almostEmptyFlagN, i == 12 ? 18'h1 : 18'h0);
            end
        end
        rd(18'h1000F);
        repeat (6) @(negedge wrClk);
        check("empty", flags.emptyFlagN, 18'h0);
        check("full", flags.fullFlagN, 18'h1);
        check("half full", flags.halfFullFlagN, 18'h1);
        @(posedge rdClk);
        outputEnN <= 1'h1;
        #1 check("bus off", busLevel, 18'hZZZZZ);
        @(posedge rdClk);
        outputEnN <= 1'h0;
        #1 check("bus on", busLevel, 18'h1000F);
        $display("drain done");
    endtask
    task automatic t_replay();
        write(8'h02, 18'h20000);
        @(posedge wrClk);
        rst <= 1'h1;
        repeat (2) @(posedge wrClk);
        rst <= 1'h0;
        syncSel <= 1'h1;
        repeat (4) @(negedge wrClk);
        check("empty", flags.emptyFlagN, 18'h0);
        check("full", flags.fullFlagN, 18'h1);
        check("word after reset", dataOut, 18'h0);
        check("almost empty", flags.almostEmptyFlagN, 18'h0);
        write(8'h03, 18'h30000);
        for (int i = 0; i < 3; i++) rd(18'(18'h30000 + i));
        @(posedge rdClk);
        rtx <= 1'h1;
        @(posedge rdClk);
        rtx <= 1'h0;
        for (int i = 0; i < 3; i++) rd(18'(18'h30000 + i));
        $display("replay done");
    endtask
    task automatic print_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'h1;
        go = 1'h0;
        readEnN = 1'h1;
        outputEnN = 1'h0;
        offsetAccessSelectN = 1'h1;
        rtx = 1'h0;
        syncSel = 1'h0;
        cascade = 1'h0;
        n = 8'h00;
        base = 18'h00000;
        repeat (2) @(posedge wrClk);
        rst <= 1'h0;
        t_offsets();
        t_fill();
        t_drain();
        t_replay();
        print_verdict();
    end
    initial begin
        #400000;
        failures++;
        print_verdict();
    end
endmodule // dcf_fifo_port_tb_top

// ---- sim/dcf_producer_model.sv ----
/*
 * Producer model: writes a run of counting words on the write clock.
 * Assumes go is pulsed for one write-clock cycle while idle.
 */
`timescale 1ns/1ns
module dcf_producer_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [7:0] n,
    input wire logic [17:0] base,
    output logic writeEnN,
    output logic [17:0] dataIn,
    output logic busy
);
    logic [7:0] left_ff;
    assign busy = left_ff != 8'h00;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_ff <= 8'h00;
            writeEnN <= 1'h1;
            dataIn <= 18'h00000;
        end else if (go && !busy) begin
            left_ff <= n;
            writeEnN <= 1'h0;
            dataIn <= base;
        end else if (left_ff > 8'h01) begin
            left_ff <= left_ff - 8'h01;
            dataIn <= dataIn + 18'h00001;
        end else begin
            // Idle data toggles so a stale word is never mistaken for a fresh one.
            left_ff <= 8'h00;
            writeEnN <= 1'h1;
            dataIn <= ~dataIn;
        end
    end
endmodule // dcf_producer_model
